// ===== src/stroll_defines.svh
`ifndef STROLL_DEFINES_SVH
`define STROLL_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define STROLL_ADDR_COUNT   8'h00
`define STROLL_ADDR_SUMMARY 8'h01
`define STROLL_ADDR_SUPPLY  8'h02
`define STROLL_ADDR_MEMTEMP 8'h03
`define STROLL_ADDR_LINK    8'h04

// ****************************************
// field positions
// ****************************************
`define STROLL_SUM_CHAIN    7
`define STROLL_SUM_COMM     5
`define STROLL_SUM_MEMTEMP  4
`define STROLL_SUM_SUPPLY   3
`define STROLL_SUM_DIAG     2
`define STROLL_SUM_RESET    1
`define STROLL_SUM_INIT     0
`define STROLL_SUP_MAIN     7
`define STROLL_SUP_ANALOG   3
`define STROLL_SUP_DIGITAL  2
`define STROLL_SUP_NVM      1
`define STROLL_SUP_SEAL     0

// ****************************************
// timing
// ****************************************
`define STROLL_CLK_PERIOD_NS  10
`define STROLL_PRESCALE_DIV   1000
`define STROLL_PRESCALE_LAST  10'h3E7
`define STROLL_RECOVERY_US    100
`define STROLL_DATAVALID_US   1000
`endif

// ===== src/stroll_pkg.sv
package stroll_pkg;
    typedef enum logic [1:0] {
        STROLL_INIT,
        STROLL_RUN
    } stroll_phase_t;

    typedef struct packed {
        logic [2:0]    sync_main;
        logic [2:0]    sync_analog;
        logic [2:0]    sync_digital;
        logic [2:0]    sync_nvm;
        logic [2:0]    sync_seal;
        logic [9:0]    prescale;
        logic [7:0]    count;
        logic [4:0]    supply;
        logic [31:0]   recovery;
        logic [31:0]   init_cnt;
        logic          diag;
        logic          reset_seen;
        stroll_phase_t phase;
        logic [7:0]    rdata;
    } stroll_state_t;
endpackage : stroll_pkg

// ===== src/stroll_regs.sv
`include "stroll_defines.svh"

module stroll_regs
    import stroll_pkg::*;
#(
    parameter int RECOVERY_CYCLES  =
        `STROLL_RECOVERY_US * 1000 / `STROLL_CLK_PERIOD_NS,
    parameter int DATAVALID_CYCLES =
        `STROLL_DATAVALID_US * 1000 / `STROLL_CLK_PERIOD_NS
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       rd_strobe,
    input  wire logic [7:0] rd_addr,
    output logic      [7:0] rd_data,
    input  wire logic       summary_status_report,
    input  wire logic       selftest_unfinished,
    input  wire logic       common_mode_fault,
    input  wire logic       selftest_fault,
    input  wire logic       link_mismatch_latched,
    input  wire logic       memory_temp_any,
    input  wire logic       diag_mode_enter,
    input  wire logic       diag_mode_exit,
    input  wire logic       main_supply_low_in,
    input  wire logic       analog_regulator_in,
    input  wire logic       digital_regulator_in,
    input  wire logic       nvm_regulator_in,
    input  wire logic       seal_break_in,
    input  wire logic       supply_report_disable,
    output logic      [7:0] device_summary_status,
    output logic      [7:0] supply_fault_status
);
    stroll_state_t st_ff;
    stroll_state_t nxt_st;

    // a fault counts once the last two synchroniser stages agree
    function automatic logic sync_set(input logic [2:0] s, input logic old);
        sync_set = (s[2] == s[1]) ? s[1] : old;
    endfunction : sync_set

    logic [4:0] raw;
    logic [4:0] live;
    logic       sum_read;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync_main    = {st_ff.sync_main[1:0], main_supply_low_in};
        nxt_st.sync_analog  = {st_ff.sync_analog[1:0], analog_regulator_in};
        nxt_st.sync_digital = {st_ff.sync_digital[1:0], digital_regulator_in};
        nxt_st.sync_nvm     = {st_ff.sync_nvm[1:0], nvm_regulator_in};
        nxt_st.sync_seal    = {st_ff.sync_seal[1:0], seal_break_in};
        sum_read = rd_strobe && (rd_addr == `STROLL_ADDR_SUMMARY);
        raw[4] = sync_set(st_ff.sync_main, 1'b0);
        raw[3] = sync_set(st_ff.sync_analog, 1'b0);
        raw[2] = sync_set(st_ff.sync_digital, 1'b0);
        raw[1] = sync_set(st_ff.sync_nvm, 1'b0);
        raw[0] = sync_set(st_ff.sync_seal, 1'b0);
        live = raw;

        if (st_ff.prescale == `STROLL_PRESCALE_LAST) begin
            nxt_st.prescale = 10'h000;
            nxt_st.count = st_ff.count + 8'h01;
        end else begin
            nxt_st.prescale = st_ff.prescale + 10'h001;
        end

        // shared recovery timer reloads on any fault
        if (|live) begin
            nxt_st.recovery = RECOVERY_CYCLES;
        end else if (st_ff.recovery != 32'h0000_0000) begin
            nxt_st.recovery = st_ff.recovery - 32'h0000_0001;
        end
        // sticky until recovery unless reporting disabled
        if (supply_report_disable) begin
            nxt_st.supply = live;
        end else if (st_ff.recovery == 32'h0000_0000 && !(|live)) begin
            nxt_st.supply = 5'h00;
        end else begin
            nxt_st.supply = st_ff.supply | live;
        end

        if (diag_mode_enter) begin
            nxt_st.diag = 1'b1;
        end else if (diag_mode_exit) begin
            nxt_st.diag = 1'b0;
        end

        // cleared by summary read or status report
        if (sum_read || summary_status_report) begin
            nxt_st.reset_seen = 1'b0;
        end

        // init flag clears after data-valid delay
        case (st_ff.phase)
            STROLL_INIT: begin
                if (st_ff.init_cnt >= DATAVALID_CYCLES - 1) begin
                    nxt_st.phase = STROLL_RUN;
                end else begin
                    nxt_st.init_cnt = st_ff.init_cnt + 32'h0000_0001;
                end
            end
            STROLL_RUN: begin
                nxt_st.phase = STROLL_RUN;
            end
            default: begin
                nxt_st.phase = STROLL_INIT;
            end
        endcase

        // read-only data path, loaded every cycle whether or not rd_strobe is set
        case (rd_addr)
            `STROLL_ADDR_COUNT:   nxt_st.rdata = st_ff.count;
            `STROLL_ADDR_SUMMARY: nxt_st.rdata = device_summary_status;
            `STROLL_ADDR_SUPPLY:  nxt_st.rdata = supply_fault_status;
            default:              nxt_st.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_ff            <= '0;
            st_ff.reset_seen <= 1'b1;
            st_ff.phase      <= STROLL_INIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign supply_fault_status = {st_ff.supply[4], 3'b000,
                                  st_ff.supply[3:0]};

    // summary recomputed from sources every clock
    assign device_summary_status = {
        selftest_unfinished | common_mode_fault | selftest_fault
            | (st_ff.phase == STROLL_INIT),
        1'b0,
        link_mismatch_latched,
        memory_temp_any,
        |st_ff.supply,
        st_ff.diag,
        st_ff.reset_seen,
        st_ff.phase == STROLL_INIT
    };

    assign rd_data = st_ff.rdata;

    // ****************************************
    // checks
    // ****************************************
    // prescaler sits on its last count: a tick is due
    sequence s_tick_due;
        st_ff.prescale == `STROLL_PRESCALE_LAST;
    endsequence

    // counter has moved one on from prev and prescaler restarted
    sequence s_tick_done(logic [7:0] prev);
        st_ff.count == prev + 8'h01 && st_ff.prescale == 10'h000;
    endsequence

    // reset held for an edge, then released
    sequence s_reset_release;
        !resetn ##1 resetn;
    endsequence

    // either strobe that clears the reset flag
    sequence s_flag_clear;
        sum_read || summary_status_report;
    endsequence

    // counter steps only on prescaler wrap
    a_count_step: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        st_ff.prescale != `STROLL_PRESCALE_LAST |=> $stable(st_ff.count))
        else $error("counter moved between ticks");

    a_count_inc: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        s_tick_due |=> s_tick_done($past(st_ff.count)))
        else $error("counter did not advance by one");

    a_count_wrap: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        st_ff.count == 8'hFF ##0 s_tick_due |=> st_ff.count == 8'h00)
        else $error("counter did not wrap to zero");

    a_prescale_wrap: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        s_tick_due |=> st_ff.prescale == 10'h000)
        else $error("prescaler did not wrap");

    a_prescale_step: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        st_ff.prescale != `STROLL_PRESCALE_LAST
            |=> st_ff.prescale == $past(st_ff.prescale) + 10'h001)
        else $error("prescaler skipped a count");

    a_prescale_range: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        st_ff.prescale <= `STROLL_PRESCALE_LAST)
        else $error("prescaler out of range");

    // count reads back one cycle later
    a_read_count: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        rd_addr == `STROLL_ADDR_COUNT |=> rd_data == $past(st_ff.count))
        else $error("count read mismatch");

    // summary reads back one cycle later
    a_read_summary: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        rd_addr == `STROLL_ADDR_SUMMARY
            |=> rd_data == $past(device_summary_status))
        else $error("summary read mismatch");

    a_read_unmapped: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        rd_addr > `STROLL_ADDR_SUPPLY |=> rd_data == 8'h00)
        else $error("unmapped read not zero");

    a_chain_flag: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        device_summary_status[7] == (selftest_unfinished | common_mode_fault
            | selftest_fault | (st_ff.phase == STROLL_INIT)))
        else $error("signal chain flag mismatch");

    a_comm_mirror: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        device_summary_status[5] == link_mismatch_latched)
        else $error("comm flag mismatch");

    a_memtemp_flag: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        device_summary_status[4] == memory_temp_any)
        else $error("memory flag mismatch");

    a_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        device_summary_status[6] == 1'b0
            && supply_fault_status[6:4] == 3'b000)
        else $error("reserved bit set");

    a_supply_sum: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        device_summary_status[3] == |supply_fault_status)
        else $error("supply summary mismatch");

    a_sync_agree: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        raw[4] |-> st_ff.sync_main[2] && st_ff.sync_main[1])
        else $error("fault taken before stages agreed");

    a_supply_latch: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        |raw |=> (st_ff.supply & $past(raw)) == $past(raw))
        else $error("supply fault not latched");

    a_timer_reload: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        |live |=> st_ff.recovery == RECOVERY_CYCLES)
        else $error("recovery timer not reloaded");

    a_timer_count: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !(|live) && st_ff.recovery != 32'h0000_0000
            |=> st_ff.recovery == $past(st_ff.recovery) - 32'h0000_0001)
        else $error("recovery timer did not count");

    a_supply_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !supply_report_disable && st_ff.recovery != 32'h0000_0000
            |=> (st_ff.supply & $past(st_ff.supply)) == $past(st_ff.supply))
        else $error("supply bit dropped during recovery");

    a_supply_follow: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        supply_report_disable |=> st_ff.supply == $past(live))
        else $error("supply bits did not follow faults");

    a_supply_clear: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !supply_report_disable && st_ff.recovery == 32'h0000_0000
            && !(|live) |=> st_ff.supply == 5'h00)
        else $error("supply bits not cleared after recovery");

    a_diag_set: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        diag_mode_enter |=> device_summary_status[2])
        else $error("test mode flag not set");

    a_diag_clear: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        diag_mode_exit && !diag_mode_enter |=> !device_summary_status[2])
        else $error("test mode flag not cleared");

    a_diag_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !diag_mode_enter && !diag_mode_exit |=> $stable(st_ff.diag))
        else $error("test mode flag changed on its own");

    // reset flag clears after read or report
    a_reset_clear: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        s_flag_clear |=> !st_ff.reset_seen)
        else $error("reset flag not cleared by read");

    a_report_clear: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        summary_status_report |=> !device_summary_status[1])
        else $error("reset flag not cleared by report");

    // reset flag holds without a clear
    a_reset_sticky: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !sum_read && !summary_status_report |=> $stable(st_ff.reset_seen))
        else $error("reset flag changed on its own");

    a_reset_flags: assert property (
        @(posedge ref_clk)
        s_reset_release |-> st_ff.reset_seen && device_summary_status[0])
        else $error("reset did not set the flags");

    // init flag falls after the delay
    a_init_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $fell(device_summary_status[0])
            |-> st_ff.init_cnt == DATAVALID_CYCLES - 1)
        else $error("init flag dropped early");

    a_init_bound: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        st_ff.phase == STROLL_INIT |-> st_ff.init_cnt < DATAVALID_CYCLES)
        else $error("init counter overran");
endmodule : stroll_regs

// ===== verification/stroll_host_model.sv
module stroll_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_data,
    output logic            rd_strobe,
    output logic      [7:0] rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rd_strobe = 1'b0;
        rd_addr   = 8'h00;
    end

    // ****************************************
    // read access
    // ****************************************
    // read only access
    // data is taken one edge after the request, as the device registers it
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        rd_addr   = a;
        rd_strobe = 1'b1;
        @(negedge ref_clk);
        rd_strobe = 1'b0;
        d         = rd_data;
    endtask : read
endmodule : stroll_host_model

// ===== verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       ref_clk, resetn, rep, link, memt, den, dex, dis;
    logic [2:0] ch;
    logic [4:0] fin;
    logic       rd_strobe;
    logic [7:0] rd_addr, rd_data, sum, sup, d, p, e;
    int         err_count, cmp_count, cyc, n;

    stroll_regs #(.RECOVERY_CYCLES(20), .DATAVALID_CYCLES(50)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .rd_strobe(rd_strobe),
        .rd_addr(rd_addr), .rd_data(rd_data), .summary_status_report(rep),
        .selftest_unfinished(ch[2]), .common_mode_fault(ch[1]),
        .selftest_fault(ch[0]), .link_mismatch_latched(link),
        .memory_temp_any(memt), .diag_mode_enter(den), .diag_mode_exit(dex),
        .main_supply_low_in(fin[4]), .analog_regulator_in(fin[3]),
        .digital_regulator_in(fin[2]), .nvm_regulator_in(fin[1]),
        .seal_break_in(fin[0]), .supply_report_disable(dis),
        .device_summary_status(sum), .supply_fault_status(sup));

    stroll_host_model host (.ref_clk(ref_clk), .rd_data(rd_data),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ****************************************
    // checking and verdict
    // ****************************************
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        cmp_count++;
        if (s !== x) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    // the whole run needs about 3300 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        {rep, link, memt, den, dex, dis} = 6'h00;
        ch = 3'h0;
        fin = 5'h00;
        resetn = 1'b0;
        repeat (5) @(negedge ref_clk);
        resetn = 1'b1;
        host.read(8'h01, d);
        chk(d, 8'h83);
        chk(sum, 8'h81);
        host.read(8'h00, d);
        chk(d, 8'h00);
        host.read(8'h05, d);
        chk(d, 8'h00);
        repeat (60) @(negedge ref_clk);
        chk(sum, 8'h00);
        // reads come every 2 cycles, so one full step is 500 reads
        for (int k = 0; k < 3; k++) begin
            n = 0;
            p = d;
            while (d === p && n < 600) begin
                host.read(8'h00, d);
                n++;
            end
            if (k > 0) chk(8'(n - 400), 8'h64);
            chk(d, p + 8'h01);
        end
        // host reads supply bits only after initialisation is over
        for (int i = 0; i < 5; i++) begin
            e = (i < 4) ? (8'h01 << i) : 8'h80;
            fin[i] = 1'b1;
            repeat (5) @(negedge ref_clk);
            host.read(8'h02, d);
            chk(d, e);
            chk(sum, 8'h08);
            fin[i] = 1'b0;
            repeat (10) @(negedge ref_clk);
            chk(sup, e);
            repeat (30) @(negedge ref_clk);
            chk(sup, 8'h00);
        end
        dis = 1'b1;
        fin[4] = 1'b1;
        repeat (5) @(negedge ref_clk);
        chk(sup, 8'h80);
        fin[4] = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk(sup, 8'h00);
        dis = 1'b0;
        for (int i = 0; i < 5; i++) begin
            e = (i < 3) ? 8'h80 : ((i == 3) ? 8'h10 : 8'h20);
            {link, memt, ch} = 5'h01 << i;
            repeat (2) @(negedge ref_clk);
            chk(sum, e);
            {link, memt, ch} = 5'h00;
            repeat (2) @(negedge ref_clk);
            chk(sum, 8'h00);
        end
        den = 1'b1;
        @(negedge ref_clk);
        den = 1'b0;
        repeat (20) @(negedge ref_clk);
        chk(sum, 8'h04);
        dex = 1'b1;
        @(negedge ref_clk);
        dex = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(sum, 8'h00);
        resetn = 1'b0;
        repeat (5) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        chk(sum, 8'h83);
        rep = 1'b1;
        @(negedge ref_clk);
        rep = 1'b0;
        @(negedge ref_clk);
        chk(sum, 8'h81);
        host.read(8'h00, d);
        chk(d, 8'h00);
        host.read(8'h01, d);
        chk(d, 8'h81);
        print_verdict();
    end
endmodule : tb
